// ==== design/artc_timer.sv ====
`timescale 1ns/1ps
module artc_timer #(
  parameter int MC_CYCLES = artc_pkg::MC_LEN
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [artc_pkg::SFR_AW-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [artc_pkg::SFR_DW-1:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [artc_pkg::SFR_DW-1:0] sfr_rdata,
  input wire logic count_input,
  input wire logic ext_interrupt_pin0,
  input wire logic ext_interrupt_pin1,
  input wire logic timer_int_enable,
  input wire logic timer_int_ack,
  input wire logic ext0_int_ack,
  input wire logic ext1_int_ack,
  output logic timer_irq,
  output logic ext0_irq,
  output logic ext1_irq
);
  import artc_pkg::*;

  // A machine cycle too short to reach the sample phase would never see the pin
  if (MC_CYCLES <= int'(SAMPLE_PHASE) || MC_CYCLES > (1 << PHASE_W)) begin : gen_bad_mc
    $error("artc_timer: MC_CYCLES out of range");
  end

  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(MC_CYCLES - 1);

  // Pin levels after three-stage filtering
  logic [2:0] pin_level;
  logic cin_level, ext_interrupt_pin0_level, ext_interrupt_pin1_level;

  artc_pin_sync #(.W(3)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({ext_interrupt_pin1, ext_interrupt_pin0, count_input}),
    .level(pin_level)
  );

  assign cin_level = pin_level[0];
  assign ext_interrupt_pin0_level = pin_level[1];
  assign ext_interrupt_pin1_level = pin_level[2];

  // Machine cycle phase
  logic [PHASE_W-1:0] phase_reg, phase_next;
  logic mc_tick, sample_point;

  always_comb begin
    phase_next = (phase_reg == PHASE_LAST) ? PHASE_RST : phase_reg + 4'h1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) phase_reg <= PHASE_RST;
    else phase_reg <= phase_next;
  end

  assign mc_tick = (phase_reg == PHASE_LAST);
  assign sample_point = (phase_reg == SAMPLE_PHASE);

  // Count pin sampling; a falling transition between samples is one event
  logic cin_samp_reg, cin_samp_next;
  logic ext_edge;

  always_comb begin
    cin_samp_next = sample_point ? cin_level : cin_samp_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cin_samp_reg <= PIN_IDLE;
    else cin_samp_reg <= cin_samp_next;
  end

  assign ext_edge = sample_point & cin_samp_reg & ~cin_level;

  // Register decode
  logic wr_ctl, wr_tl, wr_th, wr_rtl, wr_rth;
  assign wr_ctl = sfr_wr && (sfr_addr == ADDR_TIMER_CONTROL);
  assign wr_tl = sfr_wr && (sfr_addr == ADDR_COUNT_LOW);
  assign wr_th = sfr_wr && (sfr_addr == ADDR_COUNT_HIGH);
  assign wr_rtl = sfr_wr && (sfr_addr == ADDR_RELOAD_LOW);
  assign wr_rth = sfr_wr && (sfr_addr == ADDR_RELOAD_HIGH);

  // Control register and interrupt pin edge history
  logic [SFR_DW-1:0] ctl_reg, ctl_next;
  logic ext_interrupt_pin0_prev_reg, ext_interrupt_pin1_prev_reg;
  logic gating, counter_select, overflow_flag, run_control;
  logic ext0_flag, ext0_type, ext1_flag, ext1_type;

  // Field views of the control register
  assign gating = ctl_reg[BIT_GATING];
  assign counter_select = ctl_reg[BIT_COUNTER_SELECT];
  assign overflow_flag = ctl_reg[BIT_OVERFLOW_FLAG];
  assign run_control = ctl_reg[BIT_RUN_CONTROL];
  assign ext0_flag = ctl_reg[BIT_EXT0_FLAG];
  assign ext0_type = ctl_reg[BIT_EXT0_TYPE];
  assign ext1_flag = ctl_reg[BIT_EXT1_FLAG];
  assign ext1_type = ctl_reg[BIT_EXT1_TYPE];

  // Counter
  logic [CNT_W-1:0] count_reg, count_next;
  logic [CNT_W-1:0] reload_reg, reload_next;
  logic count_enable, tick, overflow;

  assign count_enable = run_control & (~gating | ext_interrupt_pin0_level);
  assign tick = count_enable & (counter_select ? ext_edge : mc_tick);
  assign overflow = tick & (count_reg == COUNT_ALL_ONES);

  // Edge mode: hardware set wins over ack or write; level mode follows pin
  function automatic logic ext_flag_calc(input logic typ, input logic flag, input logic lvl,
                                         input logic prev, input logic wr, input logic wbit,
                                         input logic ack);
    logic held;
    held = wr ? wbit : (flag & ~ack);
    ext_flag_calc = typ ? ((prev & ~lvl) | held) : ~lvl;
  endfunction

  always_comb begin
    ctl_next = ctl_reg;
    if (wr_ctl) ctl_next = sfr_wdata;
    // Overflow set beats both the vector ack and a software write
    ctl_next[BIT_OVERFLOW_FLAG] = overflow |
      (wr_ctl ? sfr_wdata[BIT_OVERFLOW_FLAG] : (overflow_flag & ~timer_int_ack));
    ctl_next[BIT_EXT0_FLAG] = ext_flag_calc(ctl_next[BIT_EXT0_TYPE], ext0_flag, ext_interrupt_pin0_level,
                                            ext_interrupt_pin0_prev_reg, wr_ctl, sfr_wdata[BIT_EXT0_FLAG],
                                            ext0_int_ack);
    ctl_next[BIT_EXT1_FLAG] = ext_flag_calc(ctl_next[BIT_EXT1_TYPE], ext1_flag, ext_interrupt_pin1_level,
                                            ext_interrupt_pin1_prev_reg, wr_ctl, sfr_wdata[BIT_EXT1_FLAG],
                                            ext1_int_ack);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_reg <= TIMER_CONTROL_RST;
      ext_interrupt_pin0_prev_reg <= PIN_IDLE;
      ext_interrupt_pin1_prev_reg <= PIN_IDLE;
    end else begin
      ctl_reg <= ctl_next;
      ext_interrupt_pin0_prev_reg <= ext_interrupt_pin0_level;
      ext_interrupt_pin1_prev_reg <= ext_interrupt_pin1_level;
    end
  end

  // Software byte writes take priority over a tick in the same cycle
  always_comb begin
    count_next = count_reg;
    if (tick) begin
      if (overflow) count_next = reload_reg;
      else count_next = count_reg + 16'h0001;
    end
    if (wr_tl) count_next[7:0] = sfr_wdata;
    if (wr_th) count_next[15:8] = sfr_wdata;
  end

  // Only software reaches the reload pair
  always_comb begin
    reload_next = reload_reg;
    if (wr_rtl) reload_next[7:0] = sfr_wdata;
    if (wr_rth) reload_next[15:8] = sfr_wdata;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= COUNT_RST;
      reload_reg <= RELOAD_RST;
    end else begin
      count_reg <= count_next;
      reload_reg <= reload_next;
    end
  end

  // Read data, registered; holds until the next read
  logic [SFR_DW-1:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_TIMER_CONTROL: rdata_next = ctl_reg;
        ADDR_COUNT_LOW: rdata_next = count_reg[7:0];
        ADDR_COUNT_HIGH: rdata_next = count_reg[15:8];
        ADDR_RELOAD_LOW: rdata_next = reload_reg[7:0];
        ADDR_RELOAD_HIGH: rdata_next = reload_reg[15:8];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rdata_reg <= 8'h00;
    else rdata_reg <= rdata_next;
  end

  // Requests come from next flag values, so they rise on the same edge as the flag
  logic timer_irq_reg, timer_irq_next;
  logic ext0_irq_reg, ext0_irq_next, ext1_irq_reg, ext1_irq_next;

  always_comb begin
    timer_irq_next = ctl_next[BIT_OVERFLOW_FLAG] & timer_int_enable;
    ext0_irq_next = ctl_next[BIT_EXT0_FLAG];
    ext1_irq_next = ctl_next[BIT_EXT1_FLAG];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_irq_reg <= 1'b0;
      ext0_irq_reg <= 1'b0;
      ext1_irq_reg <= 1'b0;
    end else begin
      timer_irq_reg <= timer_irq_next;
      ext0_irq_reg <= ext0_irq_next;
      ext1_irq_reg <= ext1_irq_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign timer_irq = timer_irq_reg;
  assign ext0_irq = ext0_irq_reg;
  assign ext1_irq = ext1_irq_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic count_wr;
  assign count_wr = wr_tl | wr_th;

  sequence seq_overflow;
    overflow && !count_wr;
  endsequence

  sequence seq_falling_edge0;
    ext0_type && !wr_ctl && ext_interrupt_pin0_level ##1 !ext_interrupt_pin0_level && ext0_type && !wr_ctl;
  endsequence

  chk_hold_when_stopped: assert property (!run_control && !count_wr |=> $stable(count_reg))
    else $error("count moved while stopped");
  chk_increment_by_one: assert property (tick && !overflow && !count_wr |=>
    count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not step by one");
  chk_reload_on_overflow: assert property (seq_overflow |=> count_reg == $past(reload_reg))
    else $error("overflow did not reload");
  chk_reload_untouched: assert property (!wr_rtl && !wr_rth |=> $stable(reload_reg))
    else $error("reload pair changed without write");
  chk_flag_on_overflow: assert property (seq_overflow |=>
    overflow_flag && timer_irq == $past(timer_int_enable))
    else $error("overflow flag not set");
  chk_irq_when_disabled: assert property (!timer_int_enable |=> !timer_irq)
    else $error("interrupt raised while disabled");
  chk_sample_phase: assert property (ext_edge |-> phase_reg == SAMPLE_PHASE)
    else $error("count pin sampled off phase");
  chk_internal_rate: assert property (tick && !counter_select |-> phase_reg == PHASE_LAST)
    else $error("internal tick off machine cycle");
  chk_external_source: assert property (tick && counter_select |-> ext_edge)
    else $error("external tick without pin edge");
  chk_gate_blocks: assert property (gating && !ext_interrupt_pin0_level |-> !tick)
    else $error("gated counter advanced");
  chk_ack_clears: assert property (timer_int_ack && !overflow && !wr_ctl |=> !overflow_flag)
    else $error("ack did not clear overflow flag");
  chk_ext_edge_flag: assert property (seq_falling_edge0 |=> ext0_flag && ext0_irq)
    else $error("edge not flagged on pin 0");

  // Edge history as the flag logic sees it
  logic edge0_seen, edge1_seen;
  assign edge0_seen = ext_interrupt_pin0_prev_reg & ~ext_interrupt_pin0_level;
  assign edge1_seen = ext_interrupt_pin1_prev_reg & ~ext_interrupt_pin1_level;

  sequence seq_falling_edge1;
    ext1_type && !wr_ctl && ext_interrupt_pin1_level ##1 !ext_interrupt_pin1_level && ext1_type && !wr_ctl;
  endsequence

  chk_ext1_edge_flag: assert property (seq_falling_edge1 |=> ext1_flag && ext1_irq)
    else $error("edge not flagged on pin 1");
  chk_ext0_ack_clears: assert property (ext0_type && ext0_int_ack && !wr_ctl && !edge0_seen |=>
    !ext0_flag)
    else $error("ack did not clear pin 0 flag");
  chk_ext1_ack_clears: assert property (ext1_type && ext1_int_ack && !wr_ctl && !edge1_seen |=>
    !ext1_flag)
    else $error("ack did not clear pin 1 flag");
  chk_ext0_level_follows: assert property (!ctl_next[BIT_EXT0_TYPE] |=>
    ext0_flag == !$past(ext_interrupt_pin0_level))
    else $error("pin 0 level flag does not follow pin");
  chk_ext1_level_follows: assert property (!ctl_next[BIT_EXT1_TYPE] |=>
    ext1_flag == !$past(ext_interrupt_pin1_level))
    else $error("pin 1 level flag does not follow pin");
  chk_ext_irq_copy: assert property (ext0_irq == ext0_flag && ext1_irq == ext1_flag)
    else $error("pin request differs from flag");
  chk_irq_needs_flag: assert property (timer_irq |-> overflow_flag)
    else $error("timer request without flag");
  chk_sample_hold: assert property ($changed(cin_samp_reg) |-> $past(sample_point))
    else $error("count pin sample moved off phase");
  chk_run_needed: assert property (tick |-> run_control)
    else $error("tick while stopped");
  chk_phase_wrap: assert property (phase_reg == PHASE_LAST |=> phase_reg == PHASE_RST)
    else $error("machine cycle did not wrap");
  chk_control_bit_order: assert property (wr_ctl |=>
    gating == $past(sfr_wdata[BIT_GATING]) && counter_select == $past(sfr_wdata[BIT_COUNTER_SELECT]) &&
    run_control == $past(sfr_wdata[BIT_RUN_CONTROL]) && ext0_type == $past(sfr_wdata[BIT_EXT0_TYPE]) &&
    ext1_type == $past(sfr_wdata[BIT_EXT1_TYPE]))
    else $error("control field landed in wrong bit");
  chk_count_low_write: assert property (wr_tl |=> count_reg[7:0] == $past(sfr_wdata))
    else $error("count_low write lost");
  chk_reload_low_write: assert property (wr_rtl |=> reload_reg[7:0] == $past(sfr_wdata))
    else $error("reload_low write lost");
endmodule

// ==== design/artc_pkg.sv ====
// Overview of operation
// - One sixteen-bit auto-reload up-counter, two bytes
// - External pin sampled once per machine cycle
// - Source is machine-cycle tick or pin transition
// - counter_select one picks pin, zero picks internal
// - Counts only while run_control set, else holds
// - Each non-overflow tick adds one, low carries high
// - Overflow loads count from reload pair
// - Reload pair changes only by software write
// - Overflow sets overflow_flag
// - overflow_flag requests interrupt only when enabled
// - Control bit order gating down to ext1_type
// - Type bit picks edge or level; flags set
package artc_pkg;
  localparam int SFR_AW = 8;
  localparam int SFR_DW = 8;
  localparam int CNT_W = 16;

  // Special function register addresses
  localparam logic [SFR_AW-1:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [SFR_AW-1:0] ADDR_COUNT_LOW = 8'h8a;
  localparam logic [SFR_AW-1:0] ADDR_RELOAD_LOW = 8'h8b;
  localparam logic [SFR_AW-1:0] ADDR_COUNT_HIGH = 8'h8c;
  localparam logic [SFR_AW-1:0] ADDR_RELOAD_HIGH = 8'h8d;

  // timer_control field positions
  localparam int BIT_GATING = 7;
  localparam int BIT_COUNTER_SELECT = 6;
  localparam int BIT_OVERFLOW_FLAG = 5;
  localparam int BIT_RUN_CONTROL = 4;
  localparam int BIT_EXT0_FLAG = 3;
  localparam int BIT_EXT0_TYPE = 2;
  localparam int BIT_EXT1_FLAG = 1;
  localparam int BIT_EXT1_TYPE = 0;

  // Reset values, plus the all-ones count that overflows
  localparam logic [SFR_DW-1:0] TIMER_CONTROL_RST = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] RELOAD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic PIN_IDLE = 1'b1;

  // Machine cycle timing in oscillator clocks
  localparam int MC_LEN = 12;
  localparam int PHASE_W = 4;
  localparam logic [PHASE_W-1:0] PHASE_RST = 4'h0;
  localparam logic [PHASE_W-1:0] SAMPLE_PHASE = 4'h6;
endpackage

// ==== design/artc_pin_sync.sv ====
`timescale 1ns/1ps
module artc_pin_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  import artc_pkg::*;

  logic [W-1:0] s1_reg, s2_reg, s3_reg, level_reg;
  logic [W-1:0] level_next;

  if (W < 1) begin : gen_bad_w
    $error("artc_pin_sync: W must be at least 1");
  end

  // A change is taken only once the second and third stages agree
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) level_next[i] = s3_reg[i];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= {W{PIN_IDLE}};
      s2_reg <= {W{PIN_IDLE}};
      s3_reg <= {W{PIN_IDLE}};
      level_reg <= {W{PIN_IDLE}};
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule

// ==== bench/artc_pin_model.sv ====
`timescale 1ns/1ps
module artc_pin_model #(
  parameter int MC = 12
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  output logic count_input,
  output logic done
);
  int i;
  int k;
  initial begin
    count_input = 1'b1;
    done = 1'b1;
    forever begin
      @(posedge clk iff go);
      done = 1'b0;
      for (i = 0; i < n_pulses; i++) begin
        // Each level spans two machine cycles, so no sample is missed
        for (k = 0; k < 4 * MC; k++) begin
          @(negedge clk);
          count_input = (k < 2 * MC) ? 1'b0 : 1'b1;
        end
      end
      done = 1'b1;
    end
  end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import artc_pkg::*;
  logic clk, resetn, sfr_wr, sfr_rd, count_input, pin0, pin1, go, done;
  logic tmr_en, tmr_ack, e0_ack, e1_ack, timer_irq, ext0_irq, ext1_irq;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, n_pulses;
  int error_cnt = 0;
  int checked = 0;

  artc_timer #(.MC_CYCLES(12)) dut_u (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .count_input(count_input), .ext_interrupt_pin0(pin0), .ext_interrupt_pin1(pin1),
    .timer_int_enable(tmr_en), .timer_int_ack(tmr_ack), .ext0_int_ack(e0_ack),
    .ext1_int_ack(e1_ack), .timer_irq(timer_irq), .ext0_irq(ext0_irq), .ext1_irq(ext1_irq));
  artc_pin_model #(.MC(12)) pins_u (.clk(clk), .go(go), .n_pulses(n_pulses),
    .count_input(count_input), .done(done));

  task automatic results();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(nm, exp, sfr_rdata);
  endtask
  // Bounded wait on timer_irq (0) or pulse train end (1)
  task automatic wait_hi(input int which);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      if ((which == 0 ? timer_irq : done) === 1'b1) return;
    end
    error_cnt++;
    $display("[ERR] wait expected 1 seen timeout");
    results();
  endtask
  task automatic pulses(input logic [7:0] n);
    @(negedge clk);
    n_pulses = n;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    wait_hi(1);
  endtask
  task automatic pulse_ack(input int which);
    @(negedge clk);
    if (which == 0) tmr_ack = 1'b1;
    else if (which == 1) e1_ack = 1'b1;
    else e0_ack = 1'b1;
    @(negedge clk);
    tmr_ack = 1'b0;
    e1_ack = 1'b0;
    e0_ack = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {resetn, sfr_wr, sfr_rd, go, tmr_en, tmr_ack, e0_ack, e1_ack} = 8'h00;
    {sfr_addr, sfr_wdata, n_pulses} = 24'h000000;
    {pin0, pin1} = 2'b11;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    rd_chk(ADDR_TIMER_CONTROL, 8'h00, "control");
    rd_chk(ADDR_COUNT_HIGH, 8'h00, "count_high");
    wr(8'h89, 8'hff);
    rd_chk(8'h89, 8'h00, "unmapped");
    rd_chk(ADDR_TIMER_CONTROL, 8'h00, "control");
    $display("test reset done");
    wr(ADDR_RELOAD_LOW, 8'hf0);
    wr(ADDR_RELOAD_HIGH, 8'hff);
    wr(ADDR_COUNT_LOW, 8'hfe);
    wr(ADDR_COUNT_HIGH, 8'hff);
    tmr_en = 1'b1;
    wr(ADDR_TIMER_CONTROL, 8'h10);
    wait_hi(0);
    rd_chk(ADDR_COUNT_LOW, 8'hf0, "count_low");
    rd_chk(ADDR_COUNT_HIGH, 8'hff, "count_high");
    wr(ADDR_TIMER_CONTROL, 8'h20);
    rd_chk(ADDR_TIMER_CONTROL, 8'h20, "control");
    rd_chk(ADDR_RELOAD_LOW, 8'hf0, "reload_low");
    rd_chk(ADDR_RELOAD_HIGH, 8'hff, "reload_high");
    tmr_en = 1'b0;
    repeat (2) @(negedge clk);
    chk("timer_irq", 8'h00, {7'h0, timer_irq});
    tmr_en = 1'b1;
    pulse_ack(0);
    rd_chk(ADDR_TIMER_CONTROL, 8'h00, "control");
    chk("timer_irq", 8'h00, {7'h0, timer_irq});
    $display("test overflow done");
    wr(ADDR_COUNT_LOW, 8'hfa);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'h10);
    // Run window is exactly 120 clocks: ten machine cycles
    repeat (118) @(negedge clk);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    rd_chk(ADDR_COUNT_LOW, 8'h04, "count_low");
    rd_chk(ADDR_COUNT_HIGH, 8'h01, "count_high");
    repeat (30) @(negedge clk);
    rd_chk(ADDR_COUNT_LOW, 8'h04, "count_low");
    $display("test internal done");
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'h50);
    pulses(8'h05);
    repeat (30) @(negedge clk);
    rd_chk(ADDR_COUNT_LOW, 8'h05, "count_low");
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'hd0);
    pin0 = 1'b0;
    pulses(8'h03);
    rd_chk(ADDR_COUNT_LOW, 8'h00, "count_low");
    pin0 = 1'b1;
    pulses(8'h02);
    repeat (30) @(negedge clk);
    rd_chk(ADDR_COUNT_LOW, 8'h02, "count_low");
    $display("test external done");
    wr(ADDR_TIMER_CONTROL, 8'h05);
    {pin0, pin1} = 2'b00;
    repeat (8) @(negedge clk);
    {pin0, pin1} = 2'b11;
    repeat (8) @(negedge clk);
    chk("ext1_irq", 8'h01, {7'h0, ext1_irq});
    chk("ext0_irq", 8'h01, {7'h0, ext0_irq});
    rd_chk(ADDR_TIMER_CONTROL, 8'h0f, "control");
    pulse_ack(1);
    chk("ext1_irq", 8'h00, {7'h0, ext1_irq});
    chk("ext0_irq", 8'h01, {7'h0, ext0_irq});
    pulse_ack(2);
    chk("ext0_irq", 8'h00, {7'h0, ext0_irq});
    wr(ADDR_TIMER_CONTROL, 8'h00);
    pin0 = 1'b0;
    repeat (8) @(negedge clk);
    rd_chk(ADDR_TIMER_CONTROL, 8'h08, "control");
    pin0 = 1'b1;
    repeat (8) @(negedge clk);
    chk("ext0_irq", 8'h00, {7'h0, ext0_irq});
    $display("test ext pins done");
    wr(ADDR_TIMER_CONTROL, 8'h20);
    @(negedge clk);
    chk("timer_irq", 8'h01, {7'h0, timer_irq});
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    chk("timer_irq", 8'h00, {7'h0, timer_irq});
    resetn = 1'b1;
    rd_chk(ADDR_TIMER_CONTROL, 8'h00, "control");
    rd_chk(ADDR_COUNT_LOW, 8'h00, "count_low");
    $display("test mid reset done");
    results();
  end
endmodule
